// *** verilog/sccr_pkg.sv ***
// constants for the slow-control command register block
package sccr_pkg;
  // command addresses of the block-transfer registers
  localparam logic [15:0] ADDR_UPLOAD = 16'h000A;
  localparam logic [15:0] ADDR_PART_CFG = 16'h000C;
  localparam logic [15:0] ADDR_RESULT = 16'h000E;
  localparam logic [15:0] ADDR_CTRL = 16'h0010;
  // field positions
  localparam int UPLOAD_REQ_BIT = 0;
  localparam int RESULT_REQ_BIT = 0;
  localparam int READBACK_BIT = 7;
  localparam int SET_BIT = 8;
  localparam int FAIL_LSB = 9;
  localparam int NUM_PART = 4;
  // reset values
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [15:0] REG_RESET = 16'h0000;
  // engine states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_UPLOAD,
    ST_READBACK,
    ST_PROGRAM,
    ST_RESULTS
  } sccr_state_e;
endpackage

// *** verilog/sccr_mem.sv ***
// configuration store: one write port, one registered read port
`timescale 1ns/100ps
module sccr_mem #(
  parameter int DW = 16,
  parameter int AW = 8
) (
  // clock
  input wire logic i_core_clk,
  // write port
  input wire logic i_we,
  input wire logic [AW-1:0] i_waddr,
  input wire logic [DW-1:0] i_wdata,
  // read port
  input wire logic i_re,
  input wire logic [AW-1:0] i_raddr,
  output logic [DW-1:0] o_rdata
);
  // storage array, no reset needed
  logic [DW-1:0] mem [0:(1<<AW)-1];
  logic [DW-1:0] next_rdata;

  // read data held unless a new read is issued
  always_comb begin
    next_rdata = o_rdata;
    if (i_re) begin
      next_rdata = mem[i_raddr];
    end
  end

  // array write and read register
  always_ff @(posedge i_core_clk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
    o_rdata <= next_rdata;
  end
endmodule

// *** verilog/sccr_top.sv ***
// slow-control command registers: upload, readback, partition setup, results
// Operation
// - upload bit starts upload, self-clears when done
// - upload overwrites stored words from base up to the word marked last
// - first upload word at base, then increment
// - partition command at 0x000C, resets zero
// - bits 12:9 flag per-partition programming failure
// - failure found comparing echo on repeat programming
// - bit 8 selects default or alternative set
// - bit 7 streams store back, self-clears
// - partition bits program partition, self-clear
// - 0x000E bit 0 forwards partition results
// - write to 0x0010 loads control register
`timescale 1ns/100ps
module sccr_top #(
  parameter int AW = 8
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_srst,
  // block-transfer command port
  input wire logic i_cmd_wr,
  input wire logic i_cmd_rd,
  input wire logic [15:0] i_cmd_addr,
  input wire logic [15:0] i_cmd_wdata,
  output logic o_rd_valid,
  output logic [15:0] o_rd_data,
  // upload data stream from the aggregator
  input wire logic i_up_valid,
  input wire logic [15:0] i_up_data,
  input wire logic i_up_last,
  // readback stream to the aggregator
  output logic o_rb_valid,
  output logic [15:0] o_rb_data,
  output logic o_rb_last,
  // partition programming stream
  output logic o_part_valid,
  output logic [3:0] o_part_sel,
  output logic [15:0] o_part_data,
  output logic o_part_last,
  input wire logic i_part_echo_valid,
  input wire logic [15:0] i_part_echo_data,
  // partition result forwarding
  output logic o_res_req,
  input wire logic i_res_valid,
  input wire logic [15:0] i_res_data,
  input wire logic i_res_last,
  output logic o_res_valid,
  output logic [15:0] o_res_data,
  output logic o_res_last,
  // board control register and busy level
  output logic [15:0] o_ctrl_reg,
  output logic o_busy
);
  localparam int NP = sccr_pkg::NUM_PART;
  // engine and register state
  sccr_pkg::sccr_state_e state, next_state;
  logic upload_pend, next_upload_pend; // upload request bit
  logic set_sel, next_set_sel; // set select bit
  logic rb_pend, next_rb_pend; // readback bit
  logic [NP-1:0] part_pend, next_part_pend; // partition action bits
  logic [NP-1:0] fail, next_fail; // failure flags
  logic res_pend, next_res_pend; // result readout bit
  logic [15:0] next_ctrl_reg;
  logic [AW-1:0] cnt, next_cnt; // stream address counter
  logic issuing, next_issuing; // reads still being issued
  logic pipe_vld, next_pipe_vld, pipe_last, next_pipe_last; // data and end flag next cycle
  logic [NP-1:0] cur_part, next_cur_part; // one-hot partition in work
  logic cur_set, next_cur_set; // set latched at programming start
  logic mismatch, next_mismatch; // echo differed from sent data
  logic [NP-1:0] prog_once, next_prog_once, last_set, next_last_set; // history and set used
  // registered outputs, next values
  logic next_rd_valid, next_rb_valid, next_rb_last;
  logic [15:0] next_rd_data, next_rb_data, next_part_data, next_res_data;
  logic next_part_valid, next_part_last, next_res_req;
  logic next_res_valid, next_res_last, next_busy;
  logic [3:0] next_part_sel;
  // memory ports
  logic mem_we, mem_re;
  logic [AW-1:0] mem_waddr, mem_raddr;
  logic [15:0] mem_rdata;
  // decoded write strobes
  logic wr_upload, wr_part, wr_result, wr_ctrl;
  logic [NP-1:0] low_pend;
  logic [NP-1:0] clr_part; // partition bits the engine clears
  logic clr_upload, clr_rb, clr_res;
  // configuration store
  sccr_mem #(.DW(16), .AW(AW)) u_mem (
    .i_core_clk(i_core_clk), .i_we(mem_we), .i_waddr(mem_waddr), .i_wdata(i_up_data),
    .i_re(mem_re), .i_raddr(mem_raddr), .o_rdata(mem_rdata)
  );
  // address decode of block-transfer writes
  always_comb begin
    wr_upload = i_cmd_wr && (i_cmd_addr == sccr_pkg::ADDR_UPLOAD);
    wr_part = i_cmd_wr && (i_cmd_addr == sccr_pkg::ADDR_PART_CFG);
    wr_result = i_cmd_wr && (i_cmd_addr == sccr_pkg::ADDR_RESULT);
    wr_ctrl = i_cmd_wr && (i_cmd_addr == sccr_pkg::ADDR_CTRL);
    low_pend = part_pend & NP'(-part_pend);
  end
  // engine, register file and output next values
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_issuing = issuing;
    next_pipe_vld = 1'b0;
    next_pipe_last = 1'b0;
    next_cur_part = cur_part;
    next_cur_set = cur_set;
    next_mismatch = mismatch;
    next_prog_once = prog_once;
    next_last_set = last_set;
    next_fail = fail;
    next_set_sel = set_sel;
    next_ctrl_reg = o_ctrl_reg;
    next_rb_valid = 1'b0;
    next_rb_last = 1'b0;
    next_rb_data = o_rb_data;
    next_part_valid = 1'b0;
    next_part_last = 1'b0;
    next_part_data = o_part_data;
    next_part_sel = o_part_sel;
    next_res_req = 1'b0;
    next_res_valid = 1'b0;
    next_res_last = 1'b0;
    next_res_data = o_res_data;
    mem_we = 1'b0;
    mem_waddr = cnt;
    mem_re = 1'b0;
    mem_raddr = cnt;
    clr_part = '0;
    clr_upload = 1'b0;
    clr_rb = 1'b0;
    clr_res = 1'b0;
    case (state)
      sccr_pkg::ST_IDLE: begin
        // fixed priority: upload, readback, programming, results
        next_cnt = '0;
        next_mismatch = 1'b0;
        if (upload_pend) begin
          next_state = sccr_pkg::ST_UPLOAD;
        end else if (rb_pend) begin
          next_issuing = 1'b1;
          next_state = sccr_pkg::ST_READBACK;
        end else if (|part_pend) begin
          next_cur_set = set_sel;
          next_cur_part = low_pend;
          next_issuing = 1'b1;
          next_state = sccr_pkg::ST_PROGRAM;
        end else if (res_pend) begin
          next_res_req = 1'b1;
          next_state = sccr_pkg::ST_RESULTS;
        end
      end
      sccr_pkg::ST_UPLOAD: begin
        // words stored from base address upward
        if (i_up_valid) begin
          // each valid word is written at the counter address, then the counter steps
          mem_we = 1'b1;
          next_cnt = cnt + 1'b1;
          if (i_up_last) begin
            clr_upload = 1'b1;
            next_state = sccr_pkg::ST_IDLE;
          end
        end
      end
      sccr_pkg::ST_READBACK: begin
        // whole store streamed to the aggregator
        if (issuing) begin
          mem_re = 1'b1;
          next_pipe_vld = 1'b1;
          next_pipe_last = &cnt;
          next_cnt = cnt + 1'b1;
          next_issuing = ~(&cnt);
        end
        if (pipe_vld) begin
          next_rb_valid = 1'b1;
          next_rb_last = pipe_last;
          next_rb_data = mem_rdata;
        end
        if (o_rb_valid && o_rb_last) begin
          clr_rb = 1'b1;
          next_state = sccr_pkg::ST_IDLE;
        end
      end
      sccr_pkg::ST_PROGRAM: begin
        // stream selected half of the store to one partition
        mem_raddr = {cur_set, cnt[AW-2:0]};
        if (issuing) begin
          mem_re = 1'b1;
          next_pipe_vld = 1'b1;
          next_pipe_last = &cnt[AW-2:0];
          next_cnt = cnt + 1'b1;
          next_issuing = ~(&cnt[AW-2:0]);
        end
        if (pipe_vld) begin
          next_part_valid = 1'b1;
          next_part_last = pipe_last;
          next_part_data = mem_rdata;
          next_part_sel = cur_part;
        end
        // echo holds previous contents of the partition
        if (o_part_valid && i_part_echo_valid && (i_part_echo_data != o_part_data)) begin
          next_mismatch = 1'b1;
        end
        if (o_part_valid && o_part_last) begin
          for (int p = 0; p < NP; p++) begin
            if (cur_part[p]) begin
              // flag judged only on repeat with same set
              if (prog_once[p] && (last_set[p] == cur_set)) begin
                next_fail[p] = next_mismatch;
              end
              next_prog_once[p] = 1'b1;
              next_last_set[p] = cur_set;
            end
          end
          clr_part = cur_part;
          next_state = sccr_pkg::ST_IDLE;
        end
      end
      sccr_pkg::ST_RESULTS: begin
        // results forwarded until the last word
        if (i_res_valid) begin
          next_res_valid = 1'b1;
          next_res_last = i_res_last;
          next_res_data = i_res_data;
          if (i_res_last) begin
            clr_res = 1'b1;
            next_state = sccr_pkg::ST_IDLE;
          end
        end
      end
      default: begin
        next_state = sccr_pkg::ST_IDLE;
      end
    endcase
    // action bits: a write of one wins over the hardware clear
    next_upload_pend = (upload_pend & ~clr_upload) |
      (wr_upload & i_cmd_wdata[sccr_pkg::UPLOAD_REQ_BIT]);
    next_rb_pend = (rb_pend & ~clr_rb) | (wr_part & i_cmd_wdata[sccr_pkg::READBACK_BIT]);
    next_part_pend = (part_pend & ~clr_part) | ({NP{wr_part}} & i_cmd_wdata[NP-1:0]);
    next_res_pend = (res_pend & ~clr_res) |
      (wr_result & i_cmd_wdata[sccr_pkg::RESULT_REQ_BIT]);
    if (wr_part) begin
      next_set_sel = i_cmd_wdata[sccr_pkg::SET_BIT];
    end
    if (wr_ctrl) begin
      next_ctrl_reg = i_cmd_wdata;
    end
    // busy level follows the next engine state
    next_busy = (next_state != sccr_pkg::ST_IDLE);
  end

  // register read answers, unmapped and control read as zero
  always_comb begin
    next_rd_valid = i_cmd_rd;
    next_rd_data = sccr_pkg::REG_RESET;
    if (i_cmd_rd) begin
      case (i_cmd_addr)
        sccr_pkg::ADDR_UPLOAD: next_rd_data[sccr_pkg::UPLOAD_REQ_BIT] = upload_pend;
        sccr_pkg::ADDR_PART_CFG: begin
          // failure flags in the status field
          next_rd_data[sccr_pkg::FAIL_LSB +: NP] = fail;
          next_rd_data[sccr_pkg::SET_BIT] = set_sel;
          next_rd_data[sccr_pkg::READBACK_BIT] = rb_pend;
          next_rd_data[NP-1:0] = part_pend;
        end
        sccr_pkg::ADDR_RESULT: next_rd_data[sccr_pkg::RESULT_REQ_BIT] = res_pend;
        default: next_rd_data = sccr_pkg::REG_RESET;
      endcase
    end
  end

  // state registers, all outputs straight from here
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      state <= sccr_pkg::ST_IDLE;
      {upload_pend, set_sel, rb_pend, res_pend} <= '0;
      part_pend <= '0;
      fail <= '0;
      o_ctrl_reg <= sccr_pkg::CTRL_RESET;
      cnt <= '0;
      // engine flags and history
      {issuing, pipe_vld, pipe_last, cur_set, mismatch} <= '0;
      cur_part <= '0;
      prog_once <= '0;
      last_set <= '0;
      // output strobes and data
      {o_rd_valid, o_rb_valid, o_rb_last, o_part_valid, o_part_last} <= '0;
      {o_res_req, o_res_valid, o_res_last, o_busy} <= '0;
      o_rd_data <= sccr_pkg::REG_RESET;
      o_rb_data <= sccr_pkg::REG_RESET;
      o_part_sel <= '0;
      o_part_data <= sccr_pkg::REG_RESET;
      o_res_data <= sccr_pkg::REG_RESET;
    end else begin
      state <= next_state;
      upload_pend <= next_upload_pend;
      set_sel <= next_set_sel;
      rb_pend <= next_rb_pend;
      part_pend <= next_part_pend;
      fail <= next_fail;
      res_pend <= next_res_pend;
      o_ctrl_reg <= next_ctrl_reg;
      cnt <= next_cnt;
      issuing <= next_issuing;
      pipe_vld <= next_pipe_vld;
      pipe_last <= next_pipe_last;
      cur_part <= next_cur_part;
      cur_set <= next_cur_set;
      mismatch <= next_mismatch;
      prog_once <= next_prog_once;
      last_set <= next_last_set;
      o_rd_valid <= next_rd_valid;
      o_rd_data <= next_rd_data;
      o_rb_valid <= next_rb_valid;
      o_rb_data <= next_rb_data;
      o_rb_last <= next_rb_last;
      o_part_valid <= next_part_valid;
      o_part_sel <= next_part_sel;
      o_part_data <= next_part_data;
      o_part_last <= next_part_last;
      o_res_req <= next_res_req;
      o_res_valid <= next_res_valid;
      o_res_data <= next_res_data;
      o_res_last <= next_res_last;
      o_busy <= next_busy;
    end
  end
endmodule

// *** verif/sccr_top_asserts.sv ***
// port assertions for the slow-control command register block
`timescale 1ns/100ps
module sccr_chk #(
  parameter int AW = 8
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_srst,
  // command port
  input wire logic i_cmd_wr,
  input wire logic i_cmd_rd,
  input wire logic [15:0] i_cmd_addr,
  input wire logic [15:0] i_cmd_wdata,
  input wire logic o_rd_valid,
  input wire logic [15:0] o_rd_data,
  // streams and levels
  input wire logic i_res_valid,
  input wire logic [15:0] i_res_data,
  input wire logic o_rb_valid,
  input wire logic o_rb_last,
  input wire logic o_part_valid,
  input wire logic [3:0] o_part_sel,
  input wire logic o_res_req,
  input wire logic o_res_valid,
  input wire logic [15:0] o_res_data,
  input wire logic [15:0] o_ctrl_reg,
  input wire logic o_busy
);
  // write aimed at the control register
  logic ctl_wr;
  assign ctl_wr = i_cmd_wr && i_cmd_addr == sccr_pkg::ADDR_CTRL;
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_srst);
  property p_rd_ans; i_cmd_rd |=> o_rd_valid; endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
  property p_ctl_load; ctl_wr |=> o_ctrl_reg == $past(i_cmd_wdata); endproperty
  a_ctl_load: assert property (p_ctl_load) else $error("ctrl not loaded");
  property p_ctl_keep; !ctl_wr |=> $stable(o_ctrl_reg); endproperty
  a_ctl_keep: assert property (p_ctl_keep) else $error("ctrl changed");
  property p_ctl_rd; i_cmd_rd && !ctl_wr && i_cmd_addr == sccr_pkg::ADDR_CTRL
    |=> o_rd_data == 16'h0000; endproperty
  a_ctl_rd: assert property (p_ctl_rd) else $error("ctrl readable");
  property p_rb_busy; o_rb_valid |-> o_busy; endproperty
  a_rb_busy: assert property (p_rb_busy) else $error("readback idle");
  property p_rb_last; o_rb_last |-> o_rb_valid ##1 !o_rb_valid; endproperty
  a_rb_last: assert property (p_rb_last) else $error("readback end");
  property p_part_sel; o_part_valid |-> $onehot(o_part_sel); endproperty
  a_part_sel: assert property (p_part_sel) else $error("part select");
  property p_res_fwd; o_res_valid |-> $past(i_res_valid) && o_res_data == $past(i_res_data);
  endproperty
  a_res_fwd: assert property (p_res_fwd) else $error("result forward");
  property p_res_req; o_res_req |=> !o_res_req; endproperty
  a_res_req: assert property (p_res_req) else $error("result request");
  property p_rsvd; o_rd_valid && $past(i_cmd_rd) && $past(i_cmd_addr) == sccr_pkg::ADDR_PART_CFG
    |-> o_rd_data[15:13] == 3'b000 && o_rd_data[6:4] == 3'b000; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits set");
endmodule

// *** verif/sccr_part_model.sv ***
// far-side model: four partitions echoing old contents, result source
`timescale 1ns/100ps
module sccr_part_model #(
  parameter int AW = 3
) (
  // clock and fault switch
  input wire logic i_core_clk,
  input wire logic i_bad,
  // programming stream and echo
  input wire logic i_part_valid,
  input wire logic [3:0] i_part_sel,
  input wire logic [15:0] i_part_data,
  input wire logic i_part_last,
  output logic o_echo_valid,
  output logic [15:0] o_echo_data,
  // result stream
  input wire logic i_res_req,
  output logic o_res_valid = 0,
  output logic [15:0] o_res_data = 0,
  output logic o_res_last = 0
);
  logic [15:0] mem [4][2**(AW-1)] = '{default: '0};
  logic [1:0] p;
  int k = 0;
  int n = 3;
  assign p = {i_part_sel[3] | i_part_sel[2], i_part_sel[3] | i_part_sel[1]};
  // echo old contents, inverted on fault
  assign o_echo_valid = i_part_valid;
  assign o_echo_data = i_part_valid ? mem[p][k] ^ {16{i_bad}} : ~mem[p][k];
  // store each programmed word
  always @(posedge i_core_clk) begin
    if (i_part_valid) begin
      mem[p][k] <= i_part_data;
      k <= i_part_last ? 0 : k + 1;
    end
  end
  always @(posedge i_core_clk) begin
    o_res_valid <= 0;
    o_res_last <= 0;
    o_res_data <= ~o_res_data;
    if (i_res_req) begin
      n <= 0;
    end else if (n < 3) begin
      o_res_valid <= 1;
      o_res_data <= 16'h5A00 + 16'(n);
      o_res_last <= n == 2;
      n <= n + 1;
    end
  end
endmodule

// *** verif/sccr_top_tb.sv ***
// self-checking bench for the slow-control command registers
`timescale 1ns/100ps
bind sccr_top sccr_chk #(.AW(AW)) sccr_chk_i (.*);
module sccr_top_tb;
  localparam int AW = 3;
  logic i_core_clk = 0, i_srst = 1, i_cmd_wr = 0, i_cmd_rd = 0, i_up_valid = 0, i_up_last = 0;
  logic [15:0] i_cmd_addr = 0, i_cmd_wdata = 0, i_up_data = 0, v;
  logic o_rd_valid, o_rb_valid, o_rb_last, o_part_valid, o_part_last, o_res_req, o_busy;
  logic i_part_echo_valid, i_res_valid, i_res_last, o_res_valid, o_res_last, bad = 0;
  logic [15:0] o_rd_data, o_rb_data, o_part_data, i_part_echo_data, i_res_data, o_res_data;
  logic [15:0] o_ctrl_reg, fl [8];
  logic [3:0] o_part_sel, pend, fv = 0;
  logic [31:0] seed = 32'h0001_1549;
  int mismatches = 0, total_checks = 0, cyc = 0, rbn = 0, pk = 0, resn = 0, cset = 0;
  int prv [4] = '{-1, -1, -1, -1};
  int st_set [6] = '{0, 0, 1, 1, 1, 1};
  logic [3:0] st_msk [6] = '{4'h1, 4'h1, 4'h1, 4'h1, 4'hf, 4'ha};
  logic st_bad [6] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1};
  sccr_top #(.AW(AW)) sccr_top_i (.*);
  sccr_part_model #(.AW(AW)) sccr_part_model_i (.i_core_clk(i_core_clk), .i_bad(bad),
    .i_part_valid(o_part_valid), .i_part_sel(o_part_sel), .i_part_data(o_part_data),
    .i_part_last(o_part_last), .o_echo_valid(i_part_echo_valid),
    .o_echo_data(i_part_echo_data), .i_res_req(o_res_req), .o_res_valid(i_res_valid),
    .o_res_data(i_res_data), .o_res_last(i_res_last));
  always #5 i_core_clk = ~i_core_clk;
  // hang guard
  always @(posedge i_core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      test_done();
    end
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic wr(logic [15:0] a, logic [15:0] d);
    @(negedge i_core_clk);
    i_cmd_wr = 1;
    i_cmd_addr = a;
    i_cmd_wdata = d;
    @(negedge i_core_clk);
    i_cmd_wr = 0;
  endtask
  task automatic rd(logic [15:0] a, logic [15:0] e);
    @(negedge i_core_clk);
    i_cmd_rd = 1;
    i_cmd_addr = a;
    @(negedge i_core_clk);
    i_cmd_rd = 0;
    chk("rd_valid", 16'h0001, 16'(o_rd_valid));
    chk("rd_data", e, o_rd_data);
  endtask
  // wait until the engine stays idle, busy dips for one cycle between partitions
  task automatic idle();
    int q;
    q = 0;
    for (int i = 0; i < 200 && q < 3; i++) begin
      @(negedge i_core_clk);
      q = (o_busy === 1'b0) ? q + 1 : 0;
    end
    chk("busy", 16'h0000, 16'(o_busy));
  endtask
  task automatic upload();
    wr(sccr_pkg::ADDR_UPLOAD, 16'h0001);
    @(negedge i_core_clk);
    for (int n = 0; n < 8; n++) begin
      fl[n] = 16'(rnd());
      i_up_valid = 1;
      i_up_data = fl[n];
      i_up_last = n == 7;
      @(negedge i_core_clk);
    end
    i_up_valid = 0;
    i_up_last = 0;
  endtask
  // stream monitors against the store model, results against the 0x5A00 pattern
  always @(negedge i_core_clk) begin
    if (o_rb_valid === 1'b1) begin
      chk("rb_data", fl[rbn], o_rb_data);
      chk("rb_last", 16'(rbn == 7), 16'(o_rb_last));
      rbn++;
    end
    if (o_part_valid === 1'b1) begin
      if (pk == 0) chk("part_sel", 16'(pend & -pend), 16'(o_part_sel));
      if (pk == 0) pend &= pend - 1;
      chk("part_data", fl[cset * 4 + pk], o_part_data);
      chk("part_last", 16'(pk == 3), 16'(o_part_last));
      pk = o_part_last ? 0 : pk + 1;
    end
    if (o_res_valid === 1'b1) begin
      chk("res_data", 16'h5A00 + 16'(resn), o_res_data);
      chk("res_last", 16'(resn == 2), 16'(o_res_last));
      resn++;
    end
  end
  initial begin
    repeat (20) @(negedge i_core_clk);
    i_srst = 0;
    rd(sccr_pkg::ADDR_PART_CFG, 16'h0000);
    rd(sccr_pkg::ADDR_UPLOAD, 16'h0000);
    rd(sccr_pkg::ADDR_RESULT, 16'h0000);
    rd(16'h0002, 16'h0000);
    v = 16'(rnd());
    wr(sccr_pkg::ADDR_CTRL, v);
    chk("ctrl", v, o_ctrl_reg);
    rd(sccr_pkg::ADDR_CTRL, 16'h0000);
    upload();
    idle();
    upload();
    idle();
    rd(sccr_pkg::ADDR_UPLOAD, 16'h0000);
    wr(sccr_pkg::ADDR_PART_CFG, 16'h0080);
    rd(sccr_pkg::ADDR_PART_CFG, 16'h0080);
    idle();
    chk("rb_count", 16'h0008, 16'(rbn));
    rd(sccr_pkg::ADDR_PART_CFG, 16'h0000);
    // programming steps: set, partitions, faulty echo
    for (int s = 0; s < 6; s++) begin
      cset = st_set[s];
      pend = st_msk[s];
      bad = st_bad[s];
      for (int p = 0; p < 4; p++) begin
        if (pend[p] && prv[p] == cset) fv[p] = bad;
        if (pend[p]) prv[p] = cset;
      end
      wr(16'(cset << 8) | 16'(pend), 16'h0000);
      wr(16'h0000, 16'h0000);
      // random status and reserved bits must be ignored
      wr(sccr_pkg::ADDR_PART_CFG, 16'(cset << 8) | 16'(pend) | (16'(rnd()) & 16'hfe70));
      idle();
      rd(sccr_pkg::ADDR_PART_CFG, (16'(fv) << 9) | 16'(cset << 8));
    end
    wr(sccr_pkg::ADDR_RESULT, 16'h0001);
    idle();
    chk("res_count", 16'h0003, 16'(resn));
    rd(sccr_pkg::ADDR_RESULT, 16'h0000);
    test_done();
  end
endmodule
